/* File: inc/oss_pkg.sv */
// Constants and types for the session request sequencer
package oss_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int DP_PULSE_US = 9000;
  localparam int DP_PULSE_CYC = DP_PULSE_US * (CLK_HZ / 1000000);
  localparam int NO_ANSWER_MS = 5500;
  localparam int NO_ANSWER_CYC = NO_ANSWER_MS * (CLK_HZ / 1000);
  localparam int SE0_IDLE_US = 2;
  localparam int SE0_IDLE_CYC = SE0_IDLE_US * (CLK_HZ / 1000000);
  localparam int DUR_W = 8;
  localparam int DUR_UNIT_CYC = 16;
  localparam int CNT_W = 32;
  localparam int IRQ_N = 4;
  localparam int IRQ_CHG = 0;
  localparam int IRQ_SEEN = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_NOANS = 3;
  typedef enum logic [2:0] {
    OSS_IDLE = 3'h0,
    OSS_SE0 = 3'h1,
    OSS_DPPU = 3'h3,
    OSS_VBPU = 3'h2,
    OSS_DISCH = 3'h6,
    OSS_WAIT = 3'h7
  } oss_state_t;
endpackage

/* File: hdl/oss_qual.sv */
// Level qualifier: pulses once when the input stays high past a width
`timescale 1ns/1ns
`default_nettype none
module oss_qual #(
  parameter int W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic lvl_i,
  input wire logic [W-1:0] min_i,
  output logic hit_o
);
  // One spare bit so the widest setting can still be exceeded
  logic [W:0] cnt_ff;
  logic done_ff;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
      hit_o <= 1'b0;
    end else if (ce_i) begin
      hit_o <= 1'b0;
      if (!lvl_i) begin
        cnt_ff <= '0;
        done_ff <= 1'b0;
      end else if (!done_ff) begin
        if (cnt_ff > {1'b0, min_i}) begin
          hit_o <= 1'b1;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end else begin
      hit_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/oss_top.sv */
// Session request sequencer: A-side detection and B-side generation
`timescale 1ns/1ns
`default_nettype none
module oss_top #(
  parameter int DP_PULSE_CYC = oss_pkg::DP_PULSE_CYC,
  parameter int NO_ANSWER_CYC = oss_pkg::NO_ANSWER_CYC,
  parameter int DUR_UNIT_CYC = oss_pkg::DUR_UNIT_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic otg_logic_clock_en_i,
  input wire logic dplus_pin_i,
  input wire logic dminus_pin_i,
  input wire logic [oss_pkg::DUR_W-1:0] srp_min_pulse_width_i,
  input wire logic srp_dataline_detect_en_i,
  input wire logic detect_en_a_i,
  input wire logic a_session_valid_flag_i,
  input wire logic b_session_valid_flag_i,
  input wire logic vbus_valid_flag_i,
  input wire logic b_side_bus_request_i,
  input wire logic dplus_pullup_wr1_i,
  input wire logic [oss_pkg::DUR_W-1:0] vbus_pulse_duration_i,
  input wire logic vbus_pulldown_option_i,
  input wire logic [oss_pkg::IRQ_N-1:0] otg_irq_mask_i,
  input wire logic [oss_pkg::IRQ_N-1:0] irq_clear_i,
  output logic vbus_drive_request_o,
  input wire logic vbus_drive_clear_i,
  output logic dplus_pullup_request_o,
  output logic dminus_pullup_request_o,
  output logic vbus_pullup_request_o,
  output logic vbus_pulldown_request_o,
  output logic dev_vbus_active_o,
  output logic pu_ack_seen_o,
  output logic [oss_pkg::IRQ_N-1:0] irq_pending_o,
  output logic irq_o
);
  logic ce;
  logic dp_s1_ff, dp_s2_ff, dm_s1_ff, dm_s2_ff;
  logic dl_hit, vb_hit;
  logic [oss_pkg::IRQ_N-1:0] ev;
  oss_pkg::oss_state_t st_ff;
  logic [oss_pkg::CNT_W-1:0] cnt_ff;
  logic req_ff;

  function automatic logic [oss_pkg::CNT_W-1:0] dur_cyc(input logic [oss_pkg::DUR_W-1:0] d);
    dur_cyc = oss_pkg::CNT_W'((d + 1) * DUR_UNIT_CYC);
  endfunction

  assign ce = clk_en_i & otg_logic_clock_en_i;

  // Pin synchronisers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dp_s1_ff <= 1'b0;
      dp_s2_ff <= 1'b0;
      dm_s1_ff <= 1'b0;
      dm_s2_ff <= 1'b0;
    end else if (clk_en_i) begin
      dp_s1_ff <= dplus_pin_i;
      dp_s2_ff <= dp_s1_ff;
      dm_s1_ff <= dminus_pin_i;
      dm_s2_ff <= dm_s1_ff;
    end
  end

  oss_qual #(.W(oss_pkg::DUR_W)) u_dl (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce && srp_dataline_detect_en_i),
    .lvl_i(dp_s2_ff | dm_s2_ff),
    .min_i(srp_min_pulse_width_i),
    .hit_o(dl_hit)
  );

  oss_qual #(.W(oss_pkg::DUR_W)) u_vb (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce && detect_en_a_i),
    .lvl_i(a_session_valid_flag_i),
    .min_i(srp_min_pulse_width_i),
    .hit_o(vb_hit)
  );

  // VBUS drive request from A-side detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      vbus_drive_request_o <= 1'b0;
    end else if (ce) begin
      if (dl_hit || vb_hit) begin
        vbus_drive_request_o <= 1'b1;
      end else if (vbus_drive_clear_i) begin
        vbus_drive_request_o <= 1'b0;
      end
    end
  end

  // B-side generation sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_ff <= oss_pkg::OSS_IDLE;
      cnt_ff <= '0;
      dplus_pullup_request_o <= 1'b0;
      vbus_pullup_request_o <= 1'b0;
      vbus_pulldown_request_o <= 1'b0;
      ev <= '0;
    end else if (ce) begin
      ev <= '0;
      if (dl_hit || vb_hit) begin
        ev[oss_pkg::IRQ_CHG] <= 1'b1;
        ev[oss_pkg::IRQ_SEEN] <= 1'b1;
      end
      cnt_ff <= cnt_ff + 1'b1;
      unique case (st_ff)
        oss_pkg::OSS_IDLE: begin
          cnt_ff <= '0;
          if (req_ff && b_session_valid_flag_i) begin
            st_ff <= oss_pkg::OSS_SE0;
          end
        end
        oss_pkg::OSS_SE0: begin
          if (dp_s2_ff || dm_s2_ff) begin
            cnt_ff <= '0;
          end else if (cnt_ff >= oss_pkg::CNT_W'(oss_pkg::SE0_IDLE_CYC - 1)) begin
            dplus_pullup_request_o <= 1'b1;
            ev[oss_pkg::IRQ_CHG] <= 1'b1;
            cnt_ff <= '0;
            st_ff <= oss_pkg::OSS_DPPU;
          end
        end
        oss_pkg::OSS_DPPU: begin
          if (cnt_ff >= oss_pkg::CNT_W'(DP_PULSE_CYC - 1)) begin
            dplus_pullup_request_o <= 1'b0;
            vbus_pullup_request_o <= 1'b1;
            ev[oss_pkg::IRQ_CHG] <= 1'b1;
            cnt_ff <= '0;
            st_ff <= oss_pkg::OSS_VBPU;
          end
        end
        oss_pkg::OSS_VBPU: begin
          if (cnt_ff >= dur_cyc(vbus_pulse_duration_i) - 1'b1) begin
            vbus_pullup_request_o <= 1'b0;
            vbus_pulldown_request_o <= vbus_pulldown_option_i;
            ev[oss_pkg::IRQ_CHG] <= 1'b1;
            cnt_ff <= '0;
            st_ff <= oss_pkg::OSS_DISCH;
          end
        end
        oss_pkg::OSS_DISCH: begin
          if (cnt_ff >= dur_cyc(vbus_pulse_duration_i) - 1'b1) begin
            ev[oss_pkg::IRQ_DONE] <= 1'b1;
            if (vbus_pulldown_request_o) begin
              vbus_pulldown_request_o <= 1'b0;
              ev[oss_pkg::IRQ_CHG] <= 1'b1;
            end
            cnt_ff <= '0;
            st_ff <= oss_pkg::OSS_WAIT;
          end
        end
        oss_pkg::OSS_WAIT: begin
          if (vbus_valid_flag_i) begin
            st_ff <= oss_pkg::OSS_IDLE;
          end else if (cnt_ff >= oss_pkg::CNT_W'(NO_ANSWER_CYC - 1)) begin
            ev[oss_pkg::IRQ_NOANS] <= 1'b1;
            st_ff <= oss_pkg::OSS_IDLE;
          end
        end
        default: st_ff <= oss_pkg::OSS_IDLE;
      endcase
    end else if (clk_en_i) begin
      // Events already handed to the flags must not be applied again
      ev <= '0;
    end
  end

  // Bus request latch, consumed when the sequence starts
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      req_ff <= 1'b0;
    end else if (ce) begin
      if (b_side_bus_request_i) begin
        req_ff <= 1'b1;
      end else if (st_ff != oss_pkg::OSS_IDLE) begin
        req_ff <= 1'b0;
      end
    end
  end

  // Handshake acknowledge and device-side VBUS view
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pu_ack_seen_o <= 1'b0;
      dev_vbus_active_o <= 1'b0;
      dminus_pullup_request_o <= 1'b0;
    end else if (ce) begin
      pu_ack_seen_o <= dplus_pullup_wr1_i;
      dev_vbus_active_o <= b_session_valid_flag_i;
      dminus_pullup_request_o <= 1'b0;
    end
  end

  // Sticky pending flags, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_pending_o <= '0;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_pending_o <= (irq_pending_o & ~irq_clear_i) | ev;
      irq_o <= |(((irq_pending_o & ~irq_clear_i) | ev) & otg_irq_mask_i);
    end
  end

  sequence dp_set_s;
    $rose(dplus_pullup_request_o);
  endsequence

  dp_chg_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    dp_set_s |-> ev[oss_pkg::IRQ_CHG]) else $error("D+ set without change event");
  dp_to_vb_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(dplus_pullup_request_o) |-> vbus_pullup_request_o && ev[oss_pkg::IRQ_CHG])
    else $error("D+ drop without VBUS pullup");
  vb_drop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(vbus_pullup_request_o) |-> vbus_pulldown_request_o == $past(vbus_pulldown_option_i))
    else $error("Pulldown does not follow option");
  det_drive_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce && (dl_hit || vb_hit)) |=> vbus_drive_request_o && ev[oss_pkg::IRQ_SEEN])
    else $error("Detection did not request VBUS");
  no_dminus_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !dminus_pullup_request_o) else $error("D- pulse requested");
  frozen_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !ce |=> $stable(st_ff) && $stable(vbus_pullup_request_o)) else $error("State moved while off");
  sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && irq_pending_o[0] && !irq_clear_i[0]) |=> irq_pending_o[0])
    else $error("Pending flag lost");
  irq_or_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i |=> irq_o == |(irq_pending_o & $past(otg_irq_mask_i)))
    else $error("Interrupt output mismatch");
  vbact_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce && b_session_valid_flag_i) |=> dev_vbus_active_o) else $error("VBUS active missing");
endmodule
`default_nettype wire

/* File: verif/oss_partner.sv */
// Transceiver and driver software model facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module oss_partner #(
  parameter int ACK_DLY = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic dplus_req_i,
  input wire logic vbus_pu_req_i,
  input wire logic vbus_pd_req_i,
  input wire logic vbus_drv_req_i,
  input wire logic rem_dp_i,
  input wire logic rem_dm_i,
  output logic dplus_line_o,
  output logic dminus_line_o,
  output logic [3:0] xcvr_o,
  output logic ack_o
);
  logic [3:0] req;
  logic [3:0] xc_ff;
  int cnt_ff;
  assign req = {vbus_drv_req_i, vbus_pd_req_i, vbus_pu_req_i, dplus_req_i};
  // Transceiver follows the requests once the slow link transfer is over
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      xc_ff <= 4'h0;
      cnt_ff <= 0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (xc_ff != req && cnt_ff < ACK_DLY) begin
        cnt_ff <= cnt_ff + 1;
      end else if (xc_ff != req) begin
        xc_ff <= req;
        cnt_ff <= 0;
        ack_o <= 1'b1;
      end else begin
        cnt_ff <= 0;
      end
    end
  end
  // Host pulldowns hold released lines low
  assign dplus_line_o = xc_ff[0] | rem_dp_i;
  assign dminus_line_o = rem_dm_i;
  assign xcvr_o = xc_ff;
endmodule
`default_nettype wire

/* File: verif/tb_oss_top.sv */
// Self-checking bench for the session request sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
`define WAITV(s, v, lim) begin n = 0; \
  while ((s) !== (v) && n < (lim)) begin @(negedge clk); n++; end end
module tb_oss_top;
  localparam int DP = 50;
  localparam int NA = 200;
  localparam int UNIT = 2;
  localparam int DUR = 4 * UNIT;
  logic clk = 0, rst = 1, run = 1, gce = 1, dl_en = 0, vb_en = 0, a_sess = 0, b_sess = 0;
  logic vbus_vld = 0, breq = 0, pd_opt = 0, drv_clr = 0, ack, dp_line, dm_line;
  logic [1:0] rem = 0;
  logic [7:0] min_w = 8'h03, dur = 8'h03;
  logic [3:0] mask = 4'h0, clr = 4'h0, pend, xcvr;
  logic drv_req, dp_req, dm_req, vpu, vpd, dev_act, ack_seen, irq, dm_bad = 0;
  int n_fail = 0, n_checks = 0, n, tick = 0, t0;
  always #25 clk = ~clk;
  oss_top #(.DP_PULSE_CYC(DP), .NO_ANSWER_CYC(NA), .DUR_UNIT_CYC(UNIT)) u_dut (
    .core_clk_i(clk), .rst_i(rst), .clk_en_i(gce), .otg_logic_clock_en_i(run),
    .dplus_pin_i(dp_line), .dminus_pin_i(dm_line), .srp_min_pulse_width_i(min_w),
    .srp_dataline_detect_en_i(dl_en), .detect_en_a_i(vb_en),
    .a_session_valid_flag_i(a_sess), .b_session_valid_flag_i(b_sess),
    .vbus_valid_flag_i(vbus_vld), .b_side_bus_request_i(breq), .dplus_pullup_wr1_i(ack),
    .vbus_pulse_duration_i(dur), .vbus_pulldown_option_i(pd_opt), .otg_irq_mask_i(mask),
    .irq_clear_i(clr), .vbus_drive_request_o(drv_req), .vbus_drive_clear_i(drv_clr),
    .dplus_pullup_request_o(dp_req), .dminus_pullup_request_o(dm_req),
    .vbus_pullup_request_o(vpu), .vbus_pulldown_request_o(vpd),
    .dev_vbus_active_o(dev_act), .pu_ack_seen_o(ack_seen), .irq_pending_o(pend), .irq_o(irq));
  oss_partner u_partner (.core_clk_i(clk), .rst_i(rst), .dplus_req_i(dp_req),
    .vbus_pu_req_i(vpu), .vbus_pd_req_i(vpd), .vbus_drv_req_i(drv_req), .xcvr_o(xcvr),
    .rem_dp_i(rem[0]), .rem_dm_i(rem[1]), .dplus_line_o(dp_line),
    .dminus_line_o(dm_line), .ack_o(ack));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Ends mid-cycle so outputs launched at the last edge have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic clr_all();
    @(posedge clk) begin clr <= 4'hF; drv_clr <= 1'b1; end
    @(posedge clk) begin clr <= 4'h0; drv_clr <= 1'b0; end
    cyc(2);
  endtask
  // Remote pulse on one line or on the session flag, then settle
  task automatic pulse(input int sel, input int len);
    @(posedge clk) if (sel < 2) rem[sel] <= 1'b1; else a_sess <= 1'b1;
    cyc(len);
    @(posedge clk) begin rem <= 2'b00; a_sess <= 1'b0; end
    cyc(8);
    @(negedge clk);
  endtask
  task automatic t_detect();
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 2; j++) begin
        clr_all();
        @(posedge clk) begin dl_en <= j[0] & (i < 2); vb_en <= j[0] & (i == 2); end
        pulse(i, 3);
        `CHK(drv_req, 1'b0)
        pulse(i, 20);
        `CHK(drv_req, j[0])
        `CHK(xcvr[3], j[0])
        `CHK(pend[1:0], {j[0], j[0]})
      end
    end
    `CHK(dev_act, 1'b0)
    $display("detect test done");
  endtask
  task automatic t_srp(input logic opt, input logic ans);
    clr_all();
    @(posedge clk) begin b_sess <= 1'b1; pd_opt <= opt; breq <= 1'b1; end
    @(posedge clk) breq <= 1'b0;
    `WAITV(dp_req, 1'b1, 100)
    t0 = tick;
    `CHK(dp_req, 1'b1)
    cyc(1);
    `CHK(pend[0], 1'b1)
    `CHK(dev_act, 1'b1)
    clr_all();
    `WAITV(ack_seen, 1'b1, 20)
    `CHK(ack_seen, 1'b1)
    `CHK(xcvr, 4'h1)
    `WAITV(dp_req, 1'b0, DP + 20)
    `CHK((tick - t0 >= DP - 2) && (tick - t0 <= DP + 2), 1'b1)
    `CHK(vpu, 1'b1)
    t0 = tick;
    cyc(3);
    `CHK(pend[0], 1'b1)
    clr_all();
    `WAITV(vpu, 1'b0, 40)
    `CHK((tick - t0 >= DUR - 2) && (tick - t0 <= DUR + 2), 1'b1)
    `CHK(vpd, opt)
    t0 = tick;
    cyc(3);
    `CHK(pend[0], 1'b1)
    clr_all();
    `WAITV(pend[2], 1'b1, 40)
    `CHK((tick - t0 >= DUR - 2) && (tick - t0 <= DUR + 4), 1'b1)
    cyc(3);
    `CHK({vpd, pend[0]}, {1'b0, opt})
    @(posedge clk) vbus_vld <= ans;
    cyc(NA - 20);
    `CHK(pend[3], 1'b0)
    cyc(50);
    `CHK(pend[3], ~ans)
    `CHK(xcvr, 4'h0)
    `CHK(dm_bad, 1'b0)
    @(posedge clk) begin vbus_vld <= 1'b0; b_sess <= 1'b0; end
    $display("srp test done");
  endtask
  task automatic t_irq();
    @(posedge clk) mask <= 4'h0;
    cyc(10);
    `CHK({pend[2], irq}, 2'b10)
    @(posedge clk) mask <= 4'h4;
    cyc(3);
    `CHK(irq, 1'b1)
    // A clear while the global enable is low must not take effect
    @(posedge clk) begin gce <= 1'b0; clr <= 4'h4; end
    @(posedge clk) clr <= 4'h0;
    @(posedge clk) gce <= 1'b1;
    cyc(2);
    `CHK(pend[2], 1'b1)
    @(posedge clk) clr <= 4'h4;
    @(posedge clk) clr <= 4'h0;
    cyc(3);
    `CHK({pend[2], irq}, 2'b00)
    $display("irq test done");
  endtask
  task automatic t_gate();
    clr_all();
    @(posedge clk) begin run <= 1'b0; dl_en <= 1'b1; b_sess <= 1'b1; breq <= 1'b1; end
    @(posedge clk) breq <= 1'b0;
    pulse(0, 20);
    cyc(100);
    `CHK({drv_req, dp_req, pend}, 6'h00)
    $display("gate test done");
  endtask
  always @(negedge clk) if (!rst && dm_req === 1'b1) dm_bad <= 1'b1;
  always @(posedge clk) begin
    tick++;
    if (tick > 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    cyc(10);
    @(posedge clk) rst <= 1'b0;
    cyc(2);
    t_detect();
    t_srp(1'b1, 1'b0);
    t_irq();
    t_srp(1'b0, 1'b1);
    t_gate();
    conclude();
  end
endmodule
`default_nettype wire
